// >>> dv/input_frame_timing_config_test.sv
// Self-checking bench for the input frame timing configuration block.
// Assumes two timing sources: pins, stopped for the loopback checks, and a free-running internal loop.
`default_nettype none

module input_frame_timing_config_test
  import frame_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT = 90000; // Cycle ceiling for the whole run

  logic        clk_i;
  logic        rst_n_i;
  logic [3:0]  addr_i;
  logic [15:0] wr_data_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [15:0] rd_data_o;
  logic        frame_strobe_o;
  logic        loop_active_o;
  logic        frame_locked_o;
  logic        pin_clk, pin_fp, pin_bnd, lp_clk, lp_fp;
  logic        pin_run, cpol, ppol, ppos;
  logic [12:0] pin_len;
  logic [15:0] d;
  logic [15:0] w;
  int          errors;
  int          comparisons;
  int          cycles;

  always #5 clk_i = ~clk_i;

  input_frame_timing_config dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .frame_clock_in_i(pin_clk),
    .frame_pulse_in_i(pin_fp), .clock_out_16m_i(lp_clk),
    .frame_pulse_out_2_i(lp_fp), .frame_strobe_o(frame_strobe_o),
    .loop_active_o(loop_active_o), .frame_locked_o(frame_locked_o)
  );

  // Pin source and the device's own loop source share one format
  tdm_timing_source #(.HALF(40.0)) pin_u (
    .run_i(pin_run), .clk_pol_i(cpol), .pulse_pol_i(ppol), .pos_i(ppos),
    .len_i(pin_len), .clk_o(pin_clk), .pulse_o(pin_fp), .bnd_o(pin_bnd)
  );
  tdm_timing_source #(.HALF(30.5)) loop_u (
    .run_i(1'b1), .clk_pol_i(cpol), .pulse_pol_i(ppol), .pos_i(ppos),
    .len_i(13'h0032), .clk_o(lp_clk), .pulse_o(lp_fp), .bnd_o()
  );

  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One-cycle strobes; read data is taken the cycle after the read edge
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 v = rd_data_o;
  endtask

  // Bounded wait for a frame strobe, then record whether it came
  task automatic strobe(input int bound, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (frame_strobe_o !== 1'b1 && n < bound);
    chk(nm, 16'h0001, 16'(frame_strobe_o));
  endtask

  function automatic logic [15:0] ctl(input logic [1:0] m, input logic lp,
    input logic ps, input logic cp, input logic fp, input logic [1:0] r);
    logic [15:0] v;
    v = 16'($urandom) & 16'h201F; // Random store-only bits
    v[CTL_MODE_LSB +: 2] = m;
    v[CTL_LOOP_BIT] = lp;
    v[CTL_POS_BIT] = ps;
    v[CTL_CKPOL_BIT] = cp;
    v[CTL_FPPOL_BIT] = fp;
    v[CTL_RATE_LSB +: 2] = r;
    return v;
  endfunction

  // A hang counts as a mismatch and closes the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    addr_i = 4'h0;
    wr_data_i = 16'h0000;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    pin_run = 1'b1;
    {cpol, ppol, ppos} = 3'h0;
    pin_len = 13'h0040;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(35));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Register port: reset value, masking, unmapped places, idle data
    rd(ADDR_CONTROL, d);
    chk("control_reset", CTL_RESET, d);
    w = 16'($urandom);
    wr(ADDR_CONTROL, w);
    wr(4'(3 + $urandom_range(12)), ~w);
    rd(ADDR_CONTROL, d);
    chk("control_rw", w & CTL_WMASK, d);
    @(posedge clk_i);
    #1 chk("rd_idle", 16'h0000, rd_data_o);
    rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    // Every clock edge, pulse polarity and position format from the pins
    for (int c = 0; c < 8; c++) begin
      {cpol, ppol, ppos} = 3'(c);
      pin_len = 13'(40 + $urandom_range(40));
      w = ctl(2'h0, 1'b0, ppos, cpol, ppol, RATE_16M);
      wr(ADDR_CONTROL, w);
      rd(ADDR_CONTROL, d);
      chk("control", w, d);
      repeat (3) @(pin_bnd);
      strobe(35, "strobe_delay");
      rd(ADDR_PERIOD, d);
      chk("period", 16'(pin_len), d);
      chk("locked_16m", 16'h0000, 16'(frame_locked_o));
    end
    rd(ADDR_STATUS, d);
    chk("seen", 16'h0001, d & 16'h0001);
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS, d);
    chk("seen_clear", 16'h0000, d & 16'h0001);
    // Loopback: pins go static, timing comes from the internal source
    wr(ADDR_CONTROL, ctl(2'h0, 1'b1, ppos, cpol, ppol, RATE_16M));
    pin_run = 1'b0;
    repeat (3) strobe(400, "loop_strobe");
    chk("loop_active", 16'h0001, 16'(loop_active_o));
    rd(ADDR_PERIOD, d);
    chk("loop_period", 16'h0032, d);
    rd(ADDR_STATUS, d);
    chk("loop_status", 16'h0004, d & 16'h000C);
    // Deliberate rate slip in loopback: the warning bit must show
    wr(ADDR_CONTROL, ctl(2'h0, 1'b1, ppos, cpol, ppol, RATE_8M));
    rd(ADDR_STATUS, d);
    chk("loop_warn", 16'h000C, d & 16'h000C);
    // Slave mode with the loop bit set still listens to the pins
    pin_len = 13'h0046;
    pin_run = 1'b1;
    wr(ADDR_CONTROL, ctl(MODE_SLAVE, 1'b1, ppos, cpol, ppol, RATE_16M));
    repeat (3) @(pin_bnd);
    strobe(35, "slave_strobe");
    chk("slave_loop", 16'h0000, 16'(loop_active_o));
    rd(ADDR_PERIOD, d);
    chk("slave_period", 16'h0046, d);
    // Rate decode: 1024 clocks lock at 8.192 MHz, not at 16.384 MHz
    pin_len = 13'h0400;
    wr(ADDR_CONTROL, ctl(2'h0, 1'b0, ppos, cpol, ppol, RATE_8M));
    repeat (3) @(pin_bnd);
    strobe(35, "lock_strobe");
    @(posedge clk_i);
    #1 chk("locked_8m", 16'h0001, 16'(frame_locked_o));
    wr(ADDR_CONTROL, ctl(2'h0, 1'b0, ppos, cpol, ppol, RATE_16M));
    #1 chk("lock_cleared", 16'h0000, 16'(frame_locked_o));
    @(pin_bnd);
    strobe(35, "relock_strobe");
    @(posedge clk_i);
    #1 chk("locked_wrong", 16'h0000, 16'(frame_locked_o));
    // Rate 10 locks at 512 clocks; reserved code 11 never locks
    pin_len = 13'h0200;
    wr(ADDR_CONTROL, ctl(2'h0, 1'b0, ppos, cpol, ppol, RATE_4M));
    repeat (2) @(pin_bnd);
    strobe(35, "lock4_strobe");
    @(posedge clk_i);
    #1 chk("locked_4m", 16'h0001, 16'(frame_locked_o));
    wr(ADDR_CONTROL, ctl(2'h0, 1'b0, ppos, cpol, ppol, 2'h3));
    @(pin_bnd);
    strobe(35, "rsvd_strobe");
    @(posedge clk_i);
    #1 chk("locked_rsvd", 16'h0000, 16'(frame_locked_o));
    give_verdict();
  end
endmodule // input_frame_timing_config_test

`default_nettype wire

// >>> dv/tdm_timing_source.sv
// Behavioural backplane timing source: link clock plus frame pulse.
// Assumes the bench sets the format inputs; they are taken once a frame.
`default_nettype none

module tdm_timing_source #(
  parameter realtime HALF = 40.0, // Half link clock period in ns
  parameter int      W    = 6     // Pulse width in link clocks
) (
  input  wire logic        run_i,
  input  wire logic        clk_pol_i,
  input  wire logic        pulse_pol_i,
  input  wire logic        pos_i,
  input  wire logic [12:0] len_i,
  output logic             clk_o,
  output logic             pulse_o,
  output logic             bnd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int   n;
  int   k;
  logic cp;
  logic pp;
  logic ps;
  logic act;

  // Half-cycle sequencer; a wide pulse makes a wrong polarity show late
  initial begin
    clk_o = 1'b0;
    pulse_o = 1'b0;
    bnd_o = 1'b0;
    #1;
    forever begin
      if (run_i !== 1'b1) begin
        clk_o = 1'b0;
        pulse_o = 1'b0;
        wait (run_i === 1'b1);
      end
      n = int'(len_i);
      cp = clk_pol_i;
      pp = pulse_pol_i;
      ps = pos_i;
      for (k = 0; k < 2 * n; k++) begin
        act = ps ? (k < 2 * W) : (k < 2 * W - 1 || k == 2 * n - 1);
        clk_o = cp ^ k[0];
        pulse_o = act ? pp : ~pp;
        if (k == 0) bnd_o = ~bnd_o;
        #HALF;
      end
    end
  end
endmodule // tdm_timing_source

`default_nettype wire

// >>> src/frame_edge_tracker.sv
// Frame boundary tracker running on one TDM link clock.
// Assumes the frame pulse is synchronous to the link clock; the control
// bits come from the core domain and are resynchronised here.
`default_nettype none

module frame_edge_tracker
  import frame_timing_pkg::*;
(
  input  wire logic             lk_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_pol_i,
  input  wire logic             pulse_pol_i,
  input  wire logic             pulse_pos_i,
  input  wire logic             frame_pulse_i,
  output logic                  frame_tgl_o,
  output logic [CNT_W-1:0]      period_o
);

  logic [1:0]       lrst_q;
  logic [2:0]       cfg_s1, cfg_s2, cfg_s3, cfg_r;
  logic             active;
  logic             rise_r, fall_r, hit, hit_q, boundary;
  logic [CNT_W-1:0] cnt_r;

  // Local reset: asserts at once, releases on this clock
  always_ff @(posedge lk_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lrst_q <= 2'h0;
    else          lrst_q <= {lrst_q[0], 1'b1};
  end

  // Control bits cross in; a change counts once stages two and three agree
  always_ff @(posedge lk_clk_i or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      cfg_s1 <= 3'h0;
      cfg_s2 <= 3'h0;
      cfg_s3 <= 3'h0;
      cfg_r  <= 3'h0;
    end else begin
      cfg_s1 <= {clk_pol_i, pulse_pol_i, pulse_pos_i};
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      for (int i = 0; i < 3; i++) begin
        if (cfg_s2[i] == cfg_s3[i]) cfg_r[i] <= cfg_s3[i];
      end
    end
  end

  // Polarity decides which pin level means an active pulse
  assign active = frame_pulse_i ^ ~cfg_r[1];

  // Pulse sampled on both edges so either edge can mark the boundary
  always_ff @(posedge lk_clk_i or negedge lrst_q[1]) begin
    if (!lrst_q[1]) rise_r <= 1'b0;
    else            rise_r <= active;
  end

  always_ff @(negedge lk_clk_i or negedge lrst_q[1]) begin
    if (!lrst_q[1]) fall_r <= 1'b0;
    else            fall_r <= active;
  end

  // A straddling pulse is caught on the boundary edge itself; a pulse that
  // starts at the boundary is caught mid-pulse on the opposite edge
  assign hit      = (cfg_r[2] ^ cfg_r[0]) ? rise_r : fall_r;
  assign boundary = hit & ~hit_q;

  // Count link clocks per frame and publish the length with a toggle
  always_ff @(posedge lk_clk_i or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      hit_q       <= 1'b0;
      cnt_r       <= '0;
      period_o    <= '0;
      frame_tgl_o <= 1'b0;
    end else begin
      hit_q <= hit;
      if (boundary) begin
        period_o    <= cnt_r + CNT_W'(1);
        cnt_r       <= '0;
        frame_tgl_o <= ~frame_tgl_o;
      end else if (cnt_r != '1) begin
        cnt_r <= cnt_r + CNT_W'(1); // Saturates when no pulse arrives
      end
    end
  end

  default clocking cb @(posedge lk_clk_i); endclocking
  default disable iff (!lrst_q[1]);

  a_period_latch: assert property (boundary |=> period_o == $past(cnt_r) + 13'h0001)
    else $error("frame length not latched at boundary");
  a_toggle_flip: assert property (boundary |=> frame_tgl_o != $past(frame_tgl_o))
    else $error("frame toggle missing at boundary");
  a_pulse_sense: assert property ((cfg_r[1] == 1'b0) |-> active == !frame_pulse_i)
    else $error("active-low pulse decoded wrongly");
  c_boundary: cover property (boundary ##1 !boundary [*3]);

endmodule // frame_edge_tracker

`default_nettype wire

// >>> src/frame_timing_pkg.sv
// Constants shared by the input frame timing configuration logic.
// Assumes a 100 MHz core clock and a TDM link clock of up to 16.384 MHz.
//
// Behaviour
// - Loopback off: frame clock and frame pulse come from the external pins.
// - Loopback on: use internal 16.384 MHz clock and frame pulse, ignore pins.
// - Loopback select is ignored while the device is in slave mode.
// - Clock polarity cleared: falling clock edge marks the frame boundary.
// - Clock polarity set: rising clock edge marks the frame boundary.
// - Pulse polarity cleared: frame pulse is active low.
// - Pulse polarity set: frame pulse is active high.
`default_nettype none

package frame_timing_pkg;

  // Register word addresses
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h1;
  localparam logic [3:0]  ADDR_PERIOD   = 4'h2;

  // Control register fields
  localparam int          CTL_MODE_LSB  = 11;
  localparam int          CTL_LOOP_BIT  = 10;
  localparam int          CTL_POS_BIT   = 9;
  localparam int          CTL_CKPOL_BIT = 8;
  localparam int          CTL_FPPOL_BIT = 7;
  localparam int          CTL_RATE_LSB  = 5;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [15:0] CTL_WMASK     = 16'h3FFF;

  // Status register fields
  localparam int          STS_SEEN_BIT  = 0;
  localparam int          STS_LOCK_BIT  = 1;
  localparam int          STS_LOOP_BIT  = 2;
  localparam int          STS_WARN_BIT  = 3;

  // Operating mode and rate encodings
  localparam logic [1:0]  MODE_SLAVE    = 2'h1;
  localparam logic [1:0]  RATE_16M      = 2'h0;
  localparam logic [1:0]  RATE_8M       = 2'h1;
  localparam logic [1:0]  RATE_4M       = 2'h2;

  // Frame length and link clock rates
  localparam int unsigned FRAME_NS      = 125000;
  localparam int unsigned KHZ_16M       = 16384;
  localparam int unsigned KHZ_8M        = 8192;
  localparam int unsigned KHZ_4M        = 4096;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int          CNT_W         = 13;
  localparam logic [CNT_W-1:0] PER_16M  = CNT_W'(FRAME_NS*KHZ_16M/NS_PER_MS);
  localparam logic [CNT_W-1:0] PER_8M   = CNT_W'(FRAME_NS*KHZ_8M/NS_PER_MS);
  localparam logic [CNT_W-1:0] PER_4M   = CNT_W'(FRAME_NS*KHZ_4M/NS_PER_MS);

  // Link clocks per frame expected for a rate code; zero when reserved
  function automatic logic [CNT_W-1:0] rate_period(input logic [1:0] rate);
    case (rate)
      RATE_16M: rate_period = PER_16M;
      RATE_8M:  rate_period = PER_8M;
      RATE_4M:  rate_period = PER_4M;
      default:  rate_period = 13'h0000;
    endcase
  endfunction

endpackage

`default_nettype wire

// >>> src/input_frame_timing_config.sv
// Input frame timing configuration: control register, loopback source
// selection and frame length check for the TDM input timing reference.
// Assumes a 100 MHz core clock, a single-cycle register port and link
// clocks that run freely; each link clock gets its own tracker.
//
// The register addresses and the plain strobed port were decided locally.
`default_nettype none

module input_frame_timing_config
  import frame_timing_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        frame_clock_in_i,
  input  wire logic        frame_pulse_in_i,
  input  wire logic        clock_out_16m_i,
  input  wire logic        frame_pulse_out_2_i,
  output logic             frame_strobe_o,
  output logic             loop_active_o,
  output logic             frame_locked_o
);

  // Source index: 0 is the external pins, 1 is the internal loop
  localparam int NSRC = 2;

  logic [1:0]       rst_q;
  logic             rst_n;
  logic [15:0]      device_control_r;
  logic [1:0]       master_slave_sel;
  logic             input_loopback_sel;
  logic             pulse_position_sel;
  logic             clock_polarity_sel;
  logic             pulse_polarity_sel;
  logic [1:0]       input_rate_sel;
  logic             slave_mode;
  logic             loop_eff_r;
  logic [NSRC-1:0]  src_clk;
  logic [NSRC-1:0]  src_pulse;
  logic [NSRC-1:0]  tgl;
  logic [CNT_W-1:0] per [NSRC];
  logic [NSRC-1:0]  tgl_s1, tgl_s2, tgl_s3, tgl_lvl_r;
  logic [NSRC-1:0]  ev;
  logic             ev_sel;
  logic [CNT_W-1:0] per_sel;
  logic [CNT_W-1:0] period_r;
  logic             seen_r;
  logic             warn_r;
  logic [15:0]      status_w;
  logic             ctl_wr;
  logic             sts_wr;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_q <= 2'h0;
    else          rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Register port decode
  assign ctl_wr = wr_en_i && (addr_i == ADDR_CONTROL);
  assign sts_wr = wr_en_i && (addr_i == ADDR_STATUS);

  // Control register; top two bits are reserved and stay zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      device_control_r <= CTL_RESET;
    end else if (ctl_wr) begin
      device_control_r <= wr_data_i & CTL_WMASK;
    end
  end

  // Field views of the control register
  assign master_slave_sel   = device_control_r[CTL_MODE_LSB +: 2];
  assign input_loopback_sel = device_control_r[CTL_LOOP_BIT];
  assign pulse_position_sel = device_control_r[CTL_POS_BIT];
  assign clock_polarity_sel = device_control_r[CTL_CKPOL_BIT];
  assign pulse_polarity_sel = device_control_r[CTL_FPPOL_BIT];
  assign input_rate_sel     = device_control_r[CTL_RATE_LSB +: 2];
  assign slave_mode         = (master_slave_sel == MODE_SLAVE);

  // Effective loopback: slave mode always uses the pins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) loop_eff_r <= 1'b0;
    else        loop_eff_r <= input_loopback_sel & ~slave_mode;
  end

  // Each source runs its own tracker on its own clock. Muxing the clocks
  // themselves would risk runt pulses, so the choice is made after the
  // crossing; the unused pins then have no effect, static or not.
  assign src_clk   = {clock_out_16m_i, frame_clock_in_i};
  assign src_pulse = {frame_pulse_out_2_i, frame_pulse_in_i};

  // One tracker and one toggle crossing per source
  generate
    for (genvar gi = 0; gi < NSRC; gi++) begin : g_src
      frame_edge_tracker u_trk (
        .lk_clk_i      (src_clk[gi]),
        .rst_n_i       (rst_n),
        .clk_pol_i     (clock_polarity_sel),
        .pulse_pol_i   (pulse_polarity_sel),
        .pulse_pos_i   (pulse_position_sel),
        .frame_pulse_i (src_pulse[gi]),
        .frame_tgl_o   (tgl[gi]),
        .period_o      (per[gi])
      );

      // Three flops; a toggle counts once stages two and three agree
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          tgl_s1[gi]    <= 1'b0;
          tgl_s2[gi]    <= 1'b0;
          tgl_s3[gi]    <= 1'b0;
          tgl_lvl_r[gi] <= 1'b0;
        end else begin
          tgl_s1[gi] <= tgl[gi];
          tgl_s2[gi] <= tgl_s1[gi];
          tgl_s3[gi] <= tgl_s2[gi];
          if (tgl_s2[gi] == tgl_s3[gi]) tgl_lvl_r[gi] <= tgl_s3[gi];
        end
      end

      assign ev[gi] = (tgl_s2[gi] == tgl_s3[gi]) &&
                      (tgl_s3[gi] != tgl_lvl_r[gi]);
    end
  endgenerate

  // Frame events and lengths from the chosen source only. The length word
  // changes once per frame on the link edge that flips the toggle, some core cycles before the toggle is seen,
  // so it is stable when sampled here.
  assign ev_sel  = loop_eff_r ? ev[1]  : ev[0];
  assign per_sel = loop_eff_r ? per[1] : per[0];

  // Frame strobe and latched length
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_strobe_o <= 1'b0;
      period_r       <= '0;
    end else begin
      frame_strobe_o <= ev_sel;
      if (ev_sel) period_r <= per_sel;
    end
  end

  // Lock: last frame length matches the selected rate; reserved code never
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_locked_o <= 1'b0;
    end else if (ctl_wr) begin
      frame_locked_o <= 1'b0; // New settings void the old verdict
    end else if (ev_sel) begin
      frame_locked_o <= (per_sel == rate_period(input_rate_sel)) &&
                        (rate_period(input_rate_sel) != '0);
    end
  end

  // Sticky frame-seen flag; write one clears, a new frame wins the tie
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
    end else if (ev_sel) begin
      seen_r <= 1'b1;
    end else if (sts_wr && wr_data_i[STS_SEEN_BIT]) begin
      seen_r <= 1'b0;
    end
  end

  // Loopback with a rate other than 16.384 MHz is a software slip
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      warn_r        <= 1'b0;
      loop_active_o <= 1'b0;
    end else begin
      warn_r        <= loop_eff_r && (input_rate_sel != RATE_16M);
      loop_active_o <= loop_eff_r;
    end
  end

  // Status word view
  always_comb begin
    status_w               = 16'h0000;
    status_w[STS_SEEN_BIT] = seen_r;
    status_w[STS_LOCK_BIT] = frame_locked_o;
    status_w[STS_LOOP_BIT] = loop_active_o;
    status_w[STS_WARN_BIT] = warn_r;
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= 16'h0000;
    end else if (rd_en_i) begin
      case (addr_i)
        ADDR_CONTROL: rd_data_o <= device_control_r;
        ADDR_STATUS:  rd_data_o <= status_w;
        ADDR_PERIOD:  rd_data_o <= {3'h0, period_r};
        default:      rd_data_o <= 16'h0000;
      endcase
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_slave_ignore: assert property (slave_mode [*2] |=> !loop_active_o)
    else $error("loopback active in slave mode");

  a_pin_source: assert property (
    (!loop_eff_r && ev[0]) |=> frame_strobe_o && period_r == $past(per[0]))
    else $error("pin frame not taken in pin mode");

  a_loop_source: assert property (
    (loop_eff_r && ev[1]) |=> frame_strobe_o && period_r == $past(per[1]))
    else $error("loop frame not taken in loopback mode");

  a_other_blocked: assert property (
    (loop_eff_r && ev[0] && !ev[1]) |=> !frame_strobe_o)
    else $error("pin frame leaked through in loopback");

  a_rate_decode: assert property (
    (ev_sel && !ctl_wr && input_rate_sel == RATE_8M && per_sel == 13'h0400)
    |=> frame_locked_o)
    else $error("8 MHz frame of 1024 clocks not locked");

  a_rate_warn: assert property (
    (loop_eff_r && input_rate_sel == RATE_8M) ##1 (loop_eff_r) |-> warn_r)
    else $error("loopback rate slip not flagged");

  a_reserved_zero: assert property (
    ctl_wr |=> device_control_r[15:14] == 2'h0 &&
               device_control_r[13:0] == $past(wr_data_i[13:0]))
    else $error("control write stored wrongly");

  a_read_once: assert property (
    (rd_en_i && addr_i == ADDR_CONTROL) |=>
      rd_data_o == $past(device_control_r) ##1
      ($past(rd_en_i) || rd_data_o == 16'h0000))
    else $error("read data timing wrong");

  a_seen_sticky: assert property ($rose(seen_r) |-> $past(ev_sel))
    else $error("frame flag set without a frame");

  // Read data per register and the idle level between reads
  a_read_idle: assert property (!rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data not zero between reads");

  a_read_status: assert property (
    (rd_en_i && addr_i == ADDR_STATUS) |=> rd_data_o == $past(status_w))
    else $error("status read data wrong");

  a_read_period: assert property (
    (rd_en_i && addr_i == ADDR_PERIOD) |=>
      rd_data_o == {3'h0, $past(period_r)})
    else $error("frame length read data wrong");

  // Frame results only move when a frame event or a write allows it
  a_strobe_event: assert property (!ev_sel |=> !frame_strobe_o)
    else $error("frame strobe without a frame event");

  a_period_hold: assert property (!ev_sel |=> $stable(period_r))
    else $error("frame length changed between frames");

  a_lock_hold: assert property (
    (!ev_sel && !ctl_wr) |=> $stable(frame_locked_o))
    else $error("lock verdict changed between frames");

  a_lock_void: assert property (ctl_wr |=> !frame_locked_o)
    else $error("control write did not void the lock");

  // Code 11 is reserved; a frame under it must never report lock
  a_lock_reserved: assert property (
    (ev_sel && input_rate_sel == 2'h3) |=> !frame_locked_o)
    else $error("reserved rate code reported lock");

  a_seen_clear: assert property (
    (sts_wr && wr_data_i[STS_SEEN_BIT] && !ev_sel) |=> !seen_r)
    else $error("frame flag not cleared by a write of one");

  // Loopback follows the control bits, and slave mode keeps the pins
  a_loop_follow: assert property (
    (input_loopback_sel && !slave_mode) |=> loop_eff_r)
    else $error("loopback not taken in master mode");

  a_loop_output: assert property (
    1'b1 |=> loop_active_o == $past(loop_eff_r))
    else $error("loopback flag does not follow the selection");

  a_slave_pins: assert property (
    (slave_mode [*2] ##0 ev[0]) |=> frame_strobe_o)
    else $error("pin frame dropped in slave mode");

  a_warn_clear: assert property (!loop_eff_r |=> !warn_r)
    else $error("rate warning without loopback");

  c_pin_frame:  cover property (!loop_eff_r && ev_sel ##1 frame_strobe_o);
  c_loop_frame: cover property (loop_eff_r && ev_sel ##1 frame_strobe_o);
  c_locked:     cover property ($rose(frame_locked_o));
  c_slave_loop: cover property (slave_mode && input_loopback_sel);

endmodule // input_frame_timing_config

`default_nettype wire
